//--- rtl/tpsh_crc16.sv
// Purpose: bytewise crc16 check on a data packet stream
// Assumes: bytes arrive lsb first in crc order
// Notes:   ok_o valid after last byte including crc bytes
`timescale 1ns/1ns
`include "tpsh_defs.svh"
module tpsh_crc16 (
	input  wire logic       mclk_i,
	input  wire logic       rst_i,
	input  wire logic       clr_i,
	input  wire logic       vld_i,
	input  wire logic [7:0] byte_i,
	output logic [15:0]     crc_o,
	output logic            ok_o
);
	logic [15:0] crc_ff;
	logic [15:0] nxt_crc;

	always_comb begin
		nxt_crc = crc_ff;
		for (int i = 0; i < 8; i++) begin
			if (nxt_crc[15] ^ byte_i[i]) begin
				nxt_crc = {nxt_crc[14:0], 1'b0} ^ `TPSH_CRC_POLY;
			end else begin
				nxt_crc = {nxt_crc[14:0], 1'b0};
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i || clr_i) begin
			crc_ff <= `TPSH_CRC_INIT;
		end else if (vld_i) begin
			crc_ff <= nxt_crc;
		end
	end

	assign crc_o = ~crc_ff;
	assign ok_o  = (crc_ff == `TPSH_CRC_RES);
endmodule

//--- rtl/tpsh_defs.svh
// Purpose: constants for the periodic split handler
// Assumes: 10 MHz mclk_i
// Notes:   depths and widths fixed
`ifndef TPSH_DEFS_SVH
`define TPSH_DEFS_SVH
`define TPSH_SS_DEPTH      16
`define TPSH_SS_AW         4
`define TPSH_CS_DEPTH      16
`define TPSH_DATA_W        8
`define TPSH_BUF_DEPTH     1024
`define TPSH_BUF_AW        10
`define TPSH_FS_INT_MAX    7'h40
`define TPSH_LS_INT_MAX    7'h08
`define TPSH_SEARCH_CYC    2
`define TPSH_CRC_INIT      16'hFFFF
`define TPSH_CRC_POLY      16'h8005
`define TPSH_CRC_RES       16'h800D
`endif

//--- rtl/tpsh_pkg.sv
// Purpose: shared types for the periodic split handler
// Assumes: nothing
// Notes:   encodings of split kind and complete-split answer
package tpsh_pkg;
	typedef enum logic [1:0] {
		TPSH_INT_OUT,
		TPSH_INT_IN,
		TPSH_ISO_OUT,
		TPSH_ISO_IN
	} tpsh_kind_type;
	typedef enum logic [2:0] {
		TPSH_ANS_NONE,
		TPSH_ANS_DATA,
		TPSH_ANS_MDATA,
		TPSH_ANS_NAK,
		TPSH_ANS_STALL,
		TPSH_ANS_ERR,
		TPSH_ANS_NYET,
		TPSH_ANS_ACK
	} tpsh_ans_type;
	typedef enum logic [2:0] {
		TPSH_RES_DATA,
		TPSH_RES_NAK,
		TPSH_RES_STALL,
		TPSH_RES_ACK,
		TPSH_RES_TERR
	} tpsh_res_type;
endpackage

//--- rtl/tpsh_top.sv
// Overview of operation
// R1: start-splits queue in arrival order; issued downstream only after microframe end
// R2: downstream outcome written to complete-split stage, then next entry
// R3: interrupt OUT start-split data holds payload with one high-speed crc
// R4: bad crc on interrupt OUT start-split discards it, no downstream run
// R5: interrupt IN start-splits stored, issued from next microframe in order
// R6: downstream handshake returned; data/NAK/STALL/error recorded in stage
// R7: transaction done in one microframe: next complete-split gives DATA0/1
// R8: downstream crc failed: complete-split answers ERR, no data
// R9: spanning transaction: first MDATA without crc check, then DATA or ERR
// R10: interrupt IN needs at most two complete-split microframes
// R11: device crc dropped; fresh high-speed crc made per complete-split
// R12: host checks crc on each piece; any failure fails whole transaction
// R13: host schedules isochronous IN start-split before earliest transaction
// R14: isochronous data moves as microframe-sized pieces, any alignment
// R15: isochronous OUT uses start-splits only, never complete-splits
// R16: host issues complete-splits in start-split order
// R17: isochronous IN: first split is start, all later are complete
// R18: isochronous OUT pieces joined locally; IN data cut at microframes; code queues and runs each OUT piece on its own
// R19: pipeline advances every microframe unconditionally
// R20: no local retry of periodic transactions after any error
// R21: isochronous IN transaction error answers complete-split with ERR
// R22: no matching complete-split entry yields NYET
// R23: first complete-split may time out during search; retry answered
// R24: entries tagged by address, endpoint and direction from split token
//
// Purpose: periodic split pipeline of a transaction translator
// Assumes: packet layer delivers decoded split tokens and data bytes
// Notes:   uframe_i pulses on each high-speed SOF
`timescale 1ns/1ns
`include "tpsh_defs.svh"
module tpsh_top (
	input  wire logic                     mclk_i,
	input  wire logic                     rst_i,
	input  wire logic                     uframe_i,
	// upstream start-split
	input  wire logic                     ss_vld_i,
	input  wire tpsh_pkg::tpsh_kind_type  ss_kind_i,
	input  wire logic [6:0]               ss_addr_i,
	input  wire logic [3:0]               ss_ep_i,
	input  wire logic                     ss_end_i,
	input  wire logic                     ss_byte_vld_i,
	input  wire logic [7:0]               ss_byte_i,
	input  wire logic                     ss_pkt_end_i,
	// upstream complete-split
	input  wire logic                     cs_vld_i,
	input  wire logic [6:0]               cs_addr_i,
	input  wire logic [3:0]               cs_ep_i,
	input  wire logic                     cs_in_i,
	input  wire logic                     cs_byte_rdy_i,
	output tpsh_pkg::tpsh_ans_type        cs_ans_o,
	output logic                          cs_ans_vld_o,
	output logic                          cs_byte_vld_o,
	output logic [7:0]                    cs_byte_o,
	output logic                          cs_crc_vld_o,
	output logic [15:0]                   cs_crc_o,
	// downstream handler
	output logic                          ds_req_o,
	output tpsh_pkg::tpsh_kind_type       ds_kind_o,
	output logic [6:0]                    ds_addr_o,
	output logic [3:0]                    ds_ep_o,
	output logic [`TPSH_BUF_AW-1:0]       ds_base_o,
	output logic [`TPSH_BUF_AW-1:0]       ds_len_o,
	input  wire logic                     ds_ack_i,
	input  wire logic                     ds_byte_vld_i,
	input  wire logic [7:0]               ds_byte_i,
	input  wire logic                     ds_done_i,
	input  wire tpsh_pkg::tpsh_res_type   ds_res_i,
	input  wire logic                     ds_crc_ok_i,
	input  wire logic [`TPSH_BUF_AW-1:0]  ds_rd_addr_i,
	output logic [7:0]                    ds_rd_data_o
);
	typedef enum {
		CS_IDLE,
		CS_SEARCH,
		CS_SEND,
		CS_CRC
	} tpsh_cs_state_type;

	localparam int SD = `TPSH_SS_DEPTH;
	localparam int CD = `TPSH_CS_DEPTH;
	localparam int AW = `TPSH_SS_AW;
	localparam int BW = `TPSH_BUF_AW;

	////////////////////////////////////////////////////////////////////////
	// start-split queue
	logic [6:0]              sq_addr_ff [SD];
	logic [3:0]              sq_ep_ff   [SD];
	tpsh_pkg::tpsh_kind_type sq_kind_ff [SD];
	logic [BW-1:0]           sq_base_ff [SD];
	logic [BW-1:0]           sq_len_ff  [SD];
	logic [SD-1:0]           sq_rel_ff;
	logic [AW:0]             sq_wr_ff;
	logic [AW:0]             sq_rd_ff;
	logic [7:0]              ob_mem [`TPSH_BUF_DEPTH];
	logic [BW-1:0]           ob_wp_ff;
	logic [BW-1:0]           pkt_base_ff;
	logic [BW-1:0]           pkt_len_ff;
	logic                    in_pkt_ff;
	logic                    iso_drop_ff;
	logic                    ss_crc_ok;
	logic                    sq_full;
	logic                    ss_take;
	logic [AW-1:0]           wi;
	logic [AW-1:0]           ri;

	tpsh_crc16 u_ss_crc (
		.mclk_i (mclk_i),
		.rst_i  (rst_i),
		.clr_i  (ss_vld_i),
		.vld_i  (ss_byte_vld_i),
		.byte_i (ss_byte_i),
		.crc_o  (),
		.ok_o   (ss_crc_ok)
	);

	assign sq_full = (sq_wr_ff - sq_rd_ff) == (AW+1)'(SD);
	assign wi      = sq_wr_ff[AW-1:0];
	assign ri      = sq_rd_ff[AW-1:0];
	// complete entry at packet end; OUT needs good crc, IN has no data
	assign ss_take = ss_pkt_end_i && in_pkt_ff && !sq_full && !iso_drop_ff
		&& (ss_crc_ok || ss_kind_i == tpsh_pkg::TPSH_INT_IN
		|| ss_kind_i == tpsh_pkg::TPSH_ISO_IN); // R3 R4

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			in_pkt_ff   <= 1'b0;
			pkt_base_ff <= '0;
			pkt_len_ff  <= '0;
			ob_wp_ff    <= '0;
		end else begin
			if (ss_vld_i) begin
				in_pkt_ff   <= 1'b1;
				pkt_base_ff <= ob_wp_ff;
				pkt_len_ff  <= '0;
			end else if (ss_byte_vld_i) begin
				pkt_len_ff <= pkt_len_ff + 1'b1;
				ob_wp_ff   <= ob_wp_ff + 1'b1;
			end
			if (ss_pkt_end_i) begin
				in_pkt_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (ss_byte_vld_i) begin
			ob_mem[ob_wp_ff] <= ss_byte_i;
		end
	end

	// a bad iso OUT piece mutes later pieces until end or a start-split of another kind
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			iso_drop_ff <= 1'b0;
		end else if (ss_pkt_end_i && in_pkt_ff) begin
			if (ss_kind_i == tpsh_pkg::TPSH_ISO_OUT && !ss_crc_ok) begin
				iso_drop_ff <= !ss_end_i;
			end else if (ss_end_i) begin
				iso_drop_ff <= 1'b0;
			end
		end else if (ss_vld_i && ss_kind_i != tpsh_pkg::TPSH_ISO_OUT) begin
			iso_drop_ff <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			sq_wr_ff <= '0;
		end else if (ss_take) begin
			sq_addr_ff[wi] <= ss_addr_i; // R24
			sq_ep_ff[wi]   <= ss_ep_i;
			sq_kind_ff[wi] <= ss_kind_i;
			// strip the two crc bytes; each iso OUT piece is queued as its own entry
			sq_base_ff[wi] <= pkt_base_ff; // R14 R18
			sq_len_ff[wi]  <= (pkt_len_ff > BW'(2)) ? pkt_len_ff - BW'(2)
				: '0;
			sq_wr_ff       <= sq_wr_ff + 1'b1; // R1 R5
		end
	end

	// entries received this microframe release at its end
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			sq_rel_ff <= '0;
		end else begin
			for (int i = 0; i < SD; i++) begin
				if (uframe_i) begin
					sq_rel_ff[i] <= {1'b0, AW'(i) - ri} <
						(sq_wr_ff - sq_rd_ff); // R1 R5 R19
				end else if (ss_take && wi == i[AW-1:0]) begin
					sq_rel_ff[i] <= 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// downstream issue, one attempt per entry
	logic busy_ff;
	logic part_ff;
	logic [AW-1:0] cw_ff;

	assign ds_req_o  = busy_ff;
	assign ds_kind_o = sq_kind_ff[ri];
	assign ds_addr_o = sq_addr_ff[ri];
	assign ds_ep_o   = sq_ep_ff[ri];
	assign ds_base_o = sq_base_ff[ri];
	assign ds_len_o  = sq_len_ff[ri];

	always_ff @(posedge mclk_i) begin
		ds_rd_data_o <= ob_mem[ds_rd_addr_i];
	end

	////////////////////////////////////////////////////////////////////////
	// complete-split stage: two microframe halves
	logic [6:0]              ce_addr_ff [CD];
	logic [3:0]              ce_ep_ff   [CD];
	tpsh_pkg::tpsh_res_type  ce_res_ff  [CD];
	logic [CD-1:0]           ce_vld_ff;
	logic [CD-1:0]           ce_fin_ff;
	logic [CD-1:0]           ce_crc_ff;
	logic [CD-1:0]           ce_in_ff;
	logic [7:0]              ce_len_ff  [CD];
	logic [7:0]              ce_dat_ff  [CD][`TPSH_FS_INT_MAX];
	logic [CD-1:0]           ce_ready_ff;
	logic [7:0]              wpos_ff;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			sq_rd_ff <= '0;
			busy_ff  <= 1'b0;
			part_ff  <= 1'b0;
			cw_ff    <= '0;
			wpos_ff  <= '0;
			ce_vld_ff <= '0;
			ce_fin_ff <= '0;
		end else begin
			// results live for one microframe only
			if (uframe_i) begin
				ce_vld_ff <= '0; // R19
			end
			if (!busy_ff && sq_rd_ff != sq_wr_ff && sq_rel_ff[ri]) begin
				busy_ff <= 1'b1;
				part_ff <= 1'b0;
				wpos_ff <= '0;
				ce_vld_ff[cw_ff] <= 1'b0;
				ce_fin_ff[cw_ff] <= 1'b0;
				ce_addr_ff[cw_ff] <= sq_addr_ff[ri]; // R24
				ce_ep_ff[cw_ff]   <= sq_ep_ff[ri];
				ce_in_ff[cw_ff]   <= sq_kind_ff[ri] inside
					{tpsh_pkg::TPSH_INT_IN, tpsh_pkg::TPSH_ISO_IN}; // R24
			end
			if (busy_ff && ds_byte_vld_i && wpos_ff < `TPSH_FS_INT_MAX) begin
				ce_dat_ff[cw_ff][wpos_ff[5:0]] <= ds_byte_i;
				wpos_ff <= wpos_ff + 1'b1;
			end
			if (busy_ff && uframe_i && wpos_ff != '0) begin
				ce_vld_ff[cw_ff] <= 1'b1; // R9 R14 R18
				ce_len_ff[cw_ff] <= wpos_ff;
				part_ff <= 1'b1;
			end
			if (busy_ff && ds_done_i) begin
				// outcome stored, then next entry; no retry
				ce_res_ff[cw_ff] <= ds_res_i; // R2 R6 R20
				ce_crc_ff[cw_ff] <= ds_crc_ok_i;
				ce_len_ff[cw_ff] <= wpos_ff;
				busy_ff  <= 1'b0;
				// iso OUT leaves no complete-split entry
				if (sq_kind_ff[ri] != tpsh_pkg::TPSH_ISO_OUT) begin
					ce_vld_ff[cw_ff] <= 1'b1; // R15
					ce_fin_ff[cw_ff] <= 1'b1;
					cw_ff <= cw_ff + 1'b1;
				end
				sq_rd_ff <= sq_rd_ff + 1'b1;
			end
		end
	end

	// results shown to host only from the microframe after they appear
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			ce_ready_ff <= '0;
		end else if (uframe_i) begin
			ce_ready_ff <= ce_vld_ff; // R7 R19
			// partial data latched now is shown at once
			if (busy_ff && wpos_ff != '0) begin
				ce_ready_ff[cw_ff] <= 1'b1; // R9
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// complete-split search and answer
	tpsh_cs_state_type st_ff;
	logic [AW-1:0] hit_ff;
	logic [7:0]    rpos_ff;
	logic [1:0]    srch_ff;
	logic          found;
	logic [AW-1:0] found_ix;
	logic [15:0]   out_crc;
	logic [7:0]    send_len;

	always_comb begin
		found    = 1'b0;
		found_ix = '0;
		for (int i = CD - 1; i >= 0; i--) begin
			if (ce_ready_ff[i] && ce_addr_ff[i] == cs_addr_i
				&& ce_ep_ff[i] == cs_ep_i
				&& ce_in_ff[i] == cs_in_i) begin // R24
				found    = 1'b1;
				found_ix = AW'(i);
			end
		end
	end

	tpsh_crc16 u_cs_crc (
		.mclk_i (mclk_i),
		.rst_i  (rst_i),
		.clr_i  (st_ff == CS_IDLE),
		.vld_i  (cs_byte_vld_o && cs_byte_rdy_i),
		.byte_i (cs_byte_o),
		.crc_o  (out_crc), // R11
		.ok_o   ()
	);

	assign send_len = ce_len_ff[hit_ff];
	assign cs_byte_vld_o = (st_ff == CS_SEND) && rpos_ff < send_len;
	assign cs_byte_o     = ce_dat_ff[hit_ff][rpos_ff[5:0]];
	assign cs_crc_vld_o  = (st_ff == CS_CRC);
	assign cs_crc_o      = out_crc;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			st_ff        <= CS_IDLE;
			hit_ff       <= '0;
			rpos_ff      <= '0;
			srch_ff      <= '0;
			cs_ans_o     <= tpsh_pkg::TPSH_ANS_NONE;
			cs_ans_vld_o <= 1'b0;
		end else begin
			cs_ans_vld_o <= 1'b0;
			case (st_ff)
				CS_IDLE: begin
					if (cs_vld_i) begin
						st_ff   <= CS_SEARCH; // R23
						srch_ff <= 2'(`TPSH_SEARCH_CYC);
					end
				end
				CS_SEARCH: begin
					if (srch_ff != '0) begin
						srch_ff <= srch_ff - 1'b1;
					end else if (!found) begin
						cs_ans_o     <= tpsh_pkg::TPSH_ANS_NYET; // R22
						cs_ans_vld_o <= 1'b1;
						st_ff        <= CS_IDLE;
					end else begin
						hit_ff       <= found_ix;
						rpos_ff      <= '0;
						cs_ans_vld_o <= 1'b1;
						st_ff        <= CS_IDLE;
						if (!ce_fin_ff[found_ix]) begin
							cs_ans_o <= tpsh_pkg::TPSH_ANS_MDATA; // R9 R10
							st_ff    <= CS_SEND;
						end else begin
							case (ce_res_ff[found_ix])
								tpsh_pkg::TPSH_RES_NAK:
									cs_ans_o <= tpsh_pkg::TPSH_ANS_NAK;
								tpsh_pkg::TPSH_RES_STALL:
									cs_ans_o <= tpsh_pkg::TPSH_ANS_STALL;
								tpsh_pkg::TPSH_RES_ACK:
									cs_ans_o <= tpsh_pkg::TPSH_ANS_ACK;
								tpsh_pkg::TPSH_RES_TERR:
									cs_ans_o <= tpsh_pkg::TPSH_ANS_ERR; // R21
								default: begin
									if (ce_crc_ff[found_ix]) begin
										cs_ans_o <= tpsh_pkg::TPSH_ANS_DATA; // R7
										st_ff    <= CS_SEND;
									end else begin
										cs_ans_o <= tpsh_pkg::TPSH_ANS_ERR; // R8
									end
								end
							endcase
						end
					end
				end
				CS_SEND: begin
					if (rpos_ff >= send_len) begin
						st_ff <= CS_CRC;
					end else if (cs_byte_rdy_i) begin
						rpos_ff <= rpos_ff + 1'b1;
					end
				end
				CS_CRC: begin
					st_ff <= CS_IDLE;
				end
				default: begin
					st_ff <= CS_IDLE;
				end
			endcase
		end
	end
endmodule

//--- sim/testbench.sv
// Purpose: self-checking bench for the periodic split handler
// Assumes: downstream stand-in answers every run request
// Notes:   crc16 reflected, init ffff, sent inverted lsb first
`timescale 1ns/1ns
`include "tpsh_defs.svh"
module testbench;
	logic                     mclk_i;
	logic                     rst_i;
	logic                     uframe_i;
	logic                     ss_vld_i;
	tpsh_pkg::tpsh_kind_type  ss_kind_i;
	logic [6:0]               ss_addr_i;
	logic                     ss_byte_vld_i;
	logic [7:0]               ss_byte_i;
	logic                     ss_pkt_end_i;
	logic                     cs_vld_i;
	logic [6:0]               cs_addr_i;
	logic                     cs_in_i;
	tpsh_pkg::tpsh_ans_type   cs_ans_o;
	logic                     cs_ans_vld_o;
	logic                     cs_byte_vld_o;
	logic [7:0]               cs_byte_o;
	logic                     cs_crc_vld_o;
	logic [15:0]              cs_crc_o;
	logic                     ds_req_o;
	tpsh_pkg::tpsh_kind_type  ds_kind_o;
	logic [6:0]               ds_addr_o;
	logic [3:0]               ds_ep_o;
	logic [`TPSH_BUF_AW-1:0]  ds_base_o;
	logic [`TPSH_BUF_AW-1:0]  ds_len_o;
	logic                     ds_done_i;
	tpsh_pkg::tpsh_res_type   ds_res_i;
	logic                     ds_crc_ok_i;
	logic                     ds_byte_vld_i;
	logic [7:0]               ds_byte_i;
	logic [`TPSH_BUF_AW-1:0]  ds_rd_addr_i;
	logic [7:0]               ds_rd_data_o;
	tpsh_pkg::tpsh_res_type   res_cfg;
	logic                     crc_ok_cfg;
	logic [6:0]               nbyte_cfg;
	logic [7:0]               req_cnt;
	logic [7:0]               buf_b [0:79];
	tpsh_pkg::tpsh_ans_type   got_ans;
	int                       got_n;
	logic [15:0]              got_crc;
	int                       mismatches;
	int                       cmp_count;
	////////////////////////////////////////////////////////////////////
	tpsh_top uut (
		.mclk_i, .rst_i, .uframe_i, .ss_vld_i, .ss_kind_i, .ss_addr_i,
		.ss_ep_i(4'h1), .ss_end_i(1'b1), .ss_byte_vld_i, .ss_byte_i,
		.ss_pkt_end_i, .cs_vld_i, .cs_addr_i, .cs_ep_i(4'h1), .cs_in_i,
		.cs_byte_rdy_i(1'b1), .cs_ans_o, .cs_ans_vld_o, .cs_byte_vld_o,
		.cs_byte_o, .cs_crc_vld_o, .cs_crc_o, .ds_req_o, .ds_kind_o,
		.ds_addr_o, .ds_ep_o, .ds_base_o, .ds_len_o,
		.ds_ack_i(1'b0), .ds_byte_vld_i, .ds_byte_i, .ds_done_i,
		.ds_res_i, .ds_crc_ok_i, .ds_rd_addr_i, .ds_rd_data_o
	);
	tpsh_ds_model ds (
		.mclk_i, .ds_req_i(ds_req_o), .res_cfg_i(res_cfg),
		.crc_ok_cfg_i(crc_ok_cfg), .nbyte_cfg_i(nbyte_cfg),
		.ds_done_o(ds_done_i), .ds_res_o(ds_res_i),
		.ds_crc_ok_o(ds_crc_ok_i), .ds_byte_vld_o(ds_byte_vld_i),
		.ds_byte_o(ds_byte_i), .req_cnt_o(req_cnt)
	);
	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end
	////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic check(input string nm, input logic [15:0] seen,
			input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task automatic frame();
		uframe_i = 1'b1;
		step(1);
		uframe_i = 1'b0;
	endtask
	task automatic wait_req(input logic v);
		int k;
		for (k = 0; k < 300 && ds_req_o !== v; k++)
			step(1);
		if (k == 300) begin
			mismatches++;
			report_and_stop();
		end
	endtask
	task automatic wait_cnt(input logic [7:0] t);
		int k;
		for (k = 0; k < 300 && req_cnt !== t; k++)
			step(1);
		if (k == 300) begin
			mismatches++;
			report_and_stop();
		end
	endtask
	function automatic logic [15:0] crc16(input int n);
		logic [15:0] c;
		c = 16'hffff;
		for (int i = 0; i < n; i++) begin
			c = c ^ {8'h00, buf_b[i]};
			for (int j = 0; j < 8; j++)
				c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		end
		return ~c;
	endfunction
	task automatic send_ss(input tpsh_pkg::tpsh_kind_type kd,
			input logic [6:0] ad, input int n, input logic bad);
		logic [15:0] c;
		for (int i = 0; i < n; i++)
			buf_b[i] = 8'h10 + i[7:0];
		c = crc16(n) ^ {15'h0000, bad};
		ss_kind_i = kd;
		ss_addr_i = ad;
		ss_vld_i = 1'b1;
		step(1);
		ss_vld_i = 1'b0;
		for (int i = 0; i < n + 2 && n > 0; i++) begin
			ss_byte_vld_i = 1'b1;
			ss_byte_i = i < n ? buf_b[i] : (i == n ? c[7:0] : c[15:8]);
			step(1);
		end
		ss_byte_vld_i = 1'b0;
		ss_pkt_end_i = 1'b1;
		step(1);
		ss_pkt_end_i = 1'b0;
		step(2);
	endtask
	task automatic do_cs(input logic [6:0] ad, input logic in);
		got_n = 0;
		got_ans = tpsh_pkg::TPSH_ANS_NONE;
		cs_addr_i = ad;
		cs_in_i = in;
		cs_vld_i = 1'b1;
		step(1);
		cs_vld_i = 1'b0;
		repeat (90) begin
			if (cs_ans_vld_o === 1'b1)
				got_ans = cs_ans_o;
			if (cs_byte_vld_o === 1'b1 && got_n < 80) begin
				buf_b[got_n] = cs_byte_o;
				got_n++;
			end
			// into wire order, x^15 at bit 0
			for (int j = 0; j < 16 && cs_crc_vld_o === 1'b1; j++)
				got_crc[j] = cs_crc_o[15 - j];
			step(1);
		end
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic t_in(input tpsh_pkg::tpsh_kind_type kd,
			input tpsh_pkg::tpsh_res_type r, input logic ok,
			input int n, input tpsh_pkg::tpsh_ans_type exp);
		logic [7:0] cnt0;
		int         ne;
		ne = exp == tpsh_pkg::TPSH_ANS_DATA ? n : 0;
		res_cfg = r;
		crc_ok_cfg = ok;
		nbyte_cfg = n[6:0];
		cnt0 = req_cnt;
		send_ss(kd, 7'h05, 0, 1'b0);
		check("req_early", ds_req_o, 16'h0000);
		frame();
		wait_req(1'b1);
		check("ds_addr", ds_addr_o, 16'h0005);
		check("ds_ep", ds_ep_o, 16'h0001);
		check("ds_kind", ds_kind_o, kd);
		wait_req(1'b0);
		do_cs(7'h05, 1'b1);
		check("ans_early", got_ans, tpsh_pkg::TPSH_ANS_NYET);
		frame();
		do_cs(7'h05, 1'b1);
		check("ans", got_ans, exp);
		check("nbytes", got_n, ne);
		for (int i = 0; i < ne; i++)
			check("byte", buf_b[i], 8'h30 + i[7:0]);
		if (ne > 0)
			check("crc", got_crc, crc16(ne));
		check("runs", req_cnt, cnt0 + 8'h01);
		$display("in split test done");
	endtask
	task automatic t_out(input logic bad);
		logic [7:0] cnt0;
		cnt0 = req_cnt;
		res_cfg = tpsh_pkg::TPSH_RES_ACK;
		nbyte_cfg = 7'h00;
		send_ss(tpsh_pkg::TPSH_INT_OUT, 7'h09, 4, bad);
		frame();
		if (bad) begin
			step(40);
			check("dropped", req_cnt, cnt0);
		end else begin
			wait_req(1'b1);
			check("ds_len", ds_len_o, 16'h0004);
			for (int i = 0; i < 4; i++) begin
				ds_rd_addr_i = ds_base_o + i[`TPSH_BUF_AW-1:0];
				step(1);
				check("payload", ds_rd_data_o, 8'h10 + i[7:0]);
			end
			wait_req(1'b0);
		end
		$display("out split test done");
	endtask
	task automatic t_iso_out();
		res_cfg = tpsh_pkg::TPSH_RES_ACK;
		nbyte_cfg = 7'h00;
		send_ss(tpsh_pkg::TPSH_ISO_OUT, 7'h0b, 4, 1'b0);
		frame();
		wait_req(1'b1);
		check("iso_kind", ds_kind_o, tpsh_pkg::TPSH_ISO_OUT);
		wait_req(1'b0);
		frame();
		do_cs(7'h0b, 1'b0);
		check("iso_cs", got_ans, tpsh_pkg::TPSH_ANS_NYET);
		$display("iso out test done");
	endtask
	task automatic t_order();
		logic [7:0] cnt0;
		cnt0 = req_cnt;
		res_cfg = tpsh_pkg::TPSH_RES_NAK;
		nbyte_cfg = 7'h00;
		send_ss(tpsh_pkg::TPSH_INT_IN, 7'h03, 0, 1'b0);
		send_ss(tpsh_pkg::TPSH_INT_IN, 7'h04, 0, 1'b0);
		frame();
		wait_cnt(cnt0 + 8'h01);
		check("first", ds_addr_o, 16'h0003);
		wait_cnt(cnt0 + 8'h02);
		check("second", ds_addr_o, 16'h0004);
		wait_req(1'b0);
		frame();
		do_cs(7'h04, 1'b1);
		check("skip_ans", got_ans, tpsh_pkg::TPSH_ANS_NAK);
		$display("order test done");
	endtask
	task automatic t_span();
		nbyte_cfg = 7'h14;
		send_ss(tpsh_pkg::TPSH_INT_IN, 7'h06, 0, 1'b0);
		frame();
		wait_req(1'b1);
		step(12);
		frame();
		do_cs(7'h06, 1'b1);
		check("mdata", got_ans, tpsh_pkg::TPSH_ANS_MDATA);
		check("part_n", got_n, 16'h0003);
		$display("span test done");
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		mismatches = 0;
		cmp_count = 0;
		rst_i = 1'b1;
		uframe_i = 1'b0;
		ss_vld_i = 1'b0;
		ss_kind_i = tpsh_pkg::TPSH_INT_IN;
		ss_addr_i = 7'h00;
		ss_byte_vld_i = 1'b0;
		ss_byte_i = 8'h00;
		ss_pkt_end_i = 1'b0;
		cs_vld_i = 1'b0;
		cs_addr_i = 7'h00;
		cs_in_i = 1'b0;
		ds_rd_addr_i = '0;
		res_cfg = tpsh_pkg::TPSH_RES_DATA;
		crc_ok_cfg = 1'b1;
		nbyte_cfg = 7'h00;
		step(4);
		rst_i = 1'b0;
		check("req_rst", ds_req_o, 16'h0000);
		t_in(tpsh_pkg::TPSH_INT_IN, tpsh_pkg::TPSH_RES_DATA, 1'b1, 5,
			tpsh_pkg::TPSH_ANS_DATA);
		t_in(tpsh_pkg::TPSH_INT_IN, tpsh_pkg::TPSH_RES_DATA, 1'b1, 64,
			tpsh_pkg::TPSH_ANS_DATA);
		t_in(tpsh_pkg::TPSH_INT_IN, tpsh_pkg::TPSH_RES_DATA, 1'b0, 5,
			tpsh_pkg::TPSH_ANS_ERR);
		t_in(tpsh_pkg::TPSH_INT_IN, tpsh_pkg::TPSH_RES_NAK, 1'b1, 0,
			tpsh_pkg::TPSH_ANS_NAK);
		t_in(tpsh_pkg::TPSH_INT_IN, tpsh_pkg::TPSH_RES_STALL, 1'b1, 0,
			tpsh_pkg::TPSH_ANS_STALL);
		t_in(tpsh_pkg::TPSH_INT_IN, tpsh_pkg::TPSH_RES_TERR, 1'b1, 0,
			tpsh_pkg::TPSH_ANS_ERR);
		t_in(tpsh_pkg::TPSH_ISO_IN, tpsh_pkg::TPSH_RES_DATA, 1'b1, 8,
			tpsh_pkg::TPSH_ANS_DATA);
		t_in(tpsh_pkg::TPSH_ISO_IN, tpsh_pkg::TPSH_RES_TERR, 1'b1, 0,
			tpsh_pkg::TPSH_ANS_ERR);
		t_out(1'b1);
		t_out(1'b0);
		t_iso_out();
		t_order();
		t_span();
		report_and_stop();
	end
endmodule

//--- sim/tpsh_ds_model.sv
// Purpose: downstream handler stand-in answering run requests
// Assumes: bench sets result and byte count before each run
// Notes:   data line shows inverse of its prior value after each run
`timescale 1ns/1ns
module tpsh_ds_model (
	input  wire logic                    mclk_i,
	input  wire logic                    ds_req_i,
	input  wire tpsh_pkg::tpsh_res_type  res_cfg_i,
	input  wire logic                    crc_ok_cfg_i,
	input  wire logic [6:0]              nbyte_cfg_i,
	output logic                         ds_done_o,
	output tpsh_pkg::tpsh_res_type       ds_res_o,
	output logic                         ds_crc_ok_o,
	output logic                         ds_byte_vld_o,
	output logic [7:0]                   ds_byte_o,
	output logic [7:0]                   req_cnt_o
);
	initial begin
		ds_done_o = 1'b0;
		ds_res_o = tpsh_pkg::TPSH_RES_NAK;
		ds_crc_ok_o = 1'b0;
		ds_byte_vld_o = 1'b0;
		ds_byte_o = 8'h00;
		req_cnt_o = 8'h00;
		forever begin
			@(posedge mclk_i);
			if (ds_req_i === 1'b1) begin
				req_cnt_o = req_cnt_o + 8'h01;
				repeat (8) @(posedge mclk_i);
				#1;
				for (int i = 0; i < nbyte_cfg_i; i++) begin
					ds_byte_vld_o = 1'b1;
					ds_byte_o = 8'h30 + i[7:0];
					@(posedge mclk_i);
					#1;
				end
				ds_byte_vld_o = 1'b0;
				ds_byte_o = ~ds_byte_o;
				// single completion, never retried
				ds_done_o = 1'b1;
				ds_res_o = res_cfg_i;
				ds_crc_ok_o = crc_ok_cfg_i;
				@(posedge mclk_i);
				#1;
				ds_done_o = 1'b0;
				repeat (2) @(posedge mclk_i);
			end
		end
	end
endmodule

//--- sim/tpsh_top_asserts.sv
// Purpose: port-level checks of the periodic split handler
// Assumes: synchronous active high reset
// Notes:   bound to tpsh_top, sees its ports only
`timescale 1ns/1ns
module tpsh_chk (
	input  wire logic                    mclk_i,
	input  wire logic                    rst_i,
	input  wire logic                    uframe_i,
	input  wire logic                    cs_vld_i,
	input  wire tpsh_pkg::tpsh_ans_type  cs_ans_o,
	input  wire logic                    cs_ans_vld_o,
	input  wire logic                    cs_byte_vld_o,
	input  wire logic                    cs_crc_vld_o,
	input  wire logic                    ds_req_o
);
	logic [1:0] frm_ff;
	// microframes seen since reset, saturating
	always_ff @(posedge mclk_i) begin
		if (rst_i)
			frm_ff <= 2'h0;
		else if (uframe_i && frm_ff != 2'h3)
			frm_ff <= frm_ff + 2'h1;
	end
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////////
	ans_pulse_a: assert property (
		cs_ans_vld_o |=> !cs_ans_vld_o)
		else $error("answer strobe longer than one cycle");
	ans_delay_a: assert property (
		cs_ans_vld_o |-> $past(cs_vld_i, 3) || $past(cs_vld_i, 4))
		else $error("answer without token at fixed delay");
	no_data_a: assert property (
		cs_ans_vld_o && cs_ans_o inside {tpsh_pkg::TPSH_ANS_ERR,
		tpsh_pkg::TPSH_ANS_NYET}
		|=> !(cs_byte_vld_o || cs_crc_vld_o) [*3])
		else $error("data sent with a handshake answer");
	data_crc_a: assert property (
		cs_ans_vld_o && cs_ans_o == tpsh_pkg::TPSH_ANS_DATA
		|-> ##[1:80] cs_crc_vld_o)
		else $error("no fresh crc after data answer");
	crc_pulse_a: assert property (
		cs_crc_vld_o |=> !cs_crc_vld_o)
		else $error("crc strobe longer than one cycle");
	req_frame_a: assert property (
		ds_req_o |-> frm_ff != 2'h0)
		else $error("downstream run before any microframe end");
	data_frame_a: assert property (
		cs_ans_vld_o && cs_ans_o == tpsh_pkg::TPSH_ANS_DATA
		|-> frm_ff >= 2'h2)
		else $error("data answered too early");
	ans_code_a: assert property (
		cs_ans_vld_o |-> cs_ans_o != tpsh_pkg::TPSH_ANS_NONE)
		else $error("answer strobe with empty code");
endmodule
bind tpsh_top tpsh_chk chk (
	.mclk_i       (mclk_i),
	.rst_i        (rst_i),
	.uframe_i     (uframe_i),
	.cs_vld_i     (cs_vld_i),
	.cs_ans_o     (cs_ans_o),
	.cs_ans_vld_o (cs_ans_vld_o),
	.cs_byte_vld_o(cs_byte_vld_o),
	.cs_crc_vld_o (cs_crc_vld_o),
	.ds_req_o     (ds_req_o)
);
